// ---- design/sgc_pkg.sv ----
// package: register map, field layout and carrier types for the switch pin control block
package sgc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_PINS = 8;
    localparam int BITS_PER_PIN = 4;
    localparam logic [ADDR_W-1:0] PIN_IO_CONTROL_ADDR = 8'hB8;
    localparam logic [ADDR_W-1:0] PME_OWNER_ADDR = 8'hBC;

    // ------------------------------------------------------------
    // field positions inside one pin nibble
    // ------------------------------------------------------------
    localparam int FLD_INPUT = 0;
    localparam int FLD_DIR = 1;
    localparam int FLD_OUT = 2;
    localparam int FLD_RSVD = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [NUM_PINS-1:0] INPUT_RESET = 8'hFF;
    localparam logic [NUM_PINS-1:0] DIR_RESET = 8'h00;
    localparam logic [NUM_PINS-1:0] OUT_RESET = 8'h00;
    localparam logic [1:0] PME_EN_RESET = 2'h0;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;

    // pins taken over by the power event capability of downstream ports 1 and 2
    localparam int PME_PIN_DSP1 = 0;
    localparam int PME_PIN_DSP2 = 1;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } sgc_req_type;

    typedef struct packed {
        logic [NUM_PINS-1:0] dout;
        logic [NUM_PINS-1:0] oe;
    } sgc_pin_drive_type;

endpackage : sgc_pkg

// ---- design/sgc_pin_cell.sv ----
// one pin: input sampling and output ownership between software and power event logic
`timescale 1ns/1ps
module sgc_pin_cell #(
    parameter logic LEVEL_RESET = 1'b1,
    parameter logic DRIVE_RESET = 1'b0,
    parameter logic OE_RESET = 1'b0
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // pin side
    input wire logic pin_in_i,
    // control
    input wire logic dir_i,
    input wire logic out_val_i,
    input wire logic pme_own_i,
    input wire logic pme_drive_i,
    input wire logic pme_oe_i,
    // results
    output logic level_o,
    output logic drive_o,
    output logic oe_o
);
    typedef struct packed {
        logic level;
        logic drive;
        logic oe;
    } sgc_cell_state_type;

    sgc_cell_state_type state;
    sgc_cell_state_type next_state;

    always_comb begin
        next_state = state;
        next_state.level = pin_in_i;
        if (pme_own_i) begin
            next_state.drive = pme_drive_i;
            next_state.oe = pme_oe_i;
        end else begin
            next_state.drive = out_val_i;
            next_state.oe = dir_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state.level <= LEVEL_RESET;
            state.drive <= DRIVE_RESET;
            state.oe <= OE_RESET;
        end else if (clk_en_i) begin
            state <= next_state;
        end
    end

    assign level_o = state.level;
    assign drive_o = state.drive;
    assign oe_o = state.oe;
endmodule : sgc_pin_cell

// ---- design/sgc_gpio.sv ----
// top: eight-pin control register of the upstream port and its pin drivers
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module sgc_gpio #(
    parameter int NUM_PINS = sgc_pkg::NUM_PINS
) (
    // clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // port identity: high in the upstream port
    input wire logic upstream_port_i,
    // register port
    input wire logic [sgc_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [sgc_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [sgc_pkg::DATA_W-1:0] reg_rdata_o,
    // power event capability of downstream ports 1 and 2
    input wire logic [1:0] vendor_power_event_capability_en_i,
    input wire logic [1:0] pme_drive_i,
    input wire logic [1:0] pme_oe_i,
    // pins
    input wire logic [NUM_PINS-1:0] pin_in_i,
    output logic [NUM_PINS-1:0] pin_out_o,
    output logic [NUM_PINS-1:0] pin_oe_o
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    if (NUM_PINS != sgc_pkg::NUM_PINS) begin : g_bad_pins
        $error("pin count must match the 32-bit register layout");
    end
    // each pin needs a whole nibble of the register word
    if (NUM_PINS * sgc_pkg::BITS_PER_PIN > sgc_pkg::DATA_W) begin : g_bad_width
        $error("register word too narrow for the pin fields");
    end
    if (sgc_pkg::FLD_RSVD >= sgc_pkg::BITS_PER_PIN) begin : g_bad_field
        $error("field position outside the pin nibble");
    end
    // the power event capability may only take over pins that exist
    if (sgc_pkg::PME_PIN_DSP1 >= NUM_PINS
        || sgc_pkg::PME_PIN_DSP2 >= NUM_PINS) begin : g_bad_pme
        $error("power event pins lie outside the port");
    end
    if (sgc_pkg::PIN_IO_CONTROL_ADDR == sgc_pkg::PME_OWNER_ADDR) begin : g_bad_map
        $error("control and owner registers share one offset");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PINS-1:0] dir;
        logic [NUM_PINS-1:0] out_val;
        logic [sgc_pkg::DATA_W-1:0] rdata;
    } sgc_top_state_type;

    // reset image of the whole register state
    localparam sgc_top_state_type STATE_RESET = '{
        dir: sgc_pkg::DIR_RESET,
        out_val: sgc_pkg::OUT_RESET,
        rdata: sgc_pkg::RDATA_RESET
    };

    sgc_top_state_type state;
    sgc_top_state_type next_state;
    sgc_pkg::sgc_req_type req;
    sgc_pkg::sgc_pin_drive_type pins;
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] pme_own;
    logic [NUM_PINS-1:0] pme_d;
    logic [NUM_PINS-1:0] pme_e;
    logic hit_ctl;
    logic hit_pme;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb begin
        req.addr = reg_addr_i;
        req.wdata = reg_wdata_i;
        req.wr = reg_wr_i;
        req.rd = reg_rd_i;
    end
    // downstream ports leave this offset unmapped
    assign hit_ctl = upstream_port_i && (req.addr == sgc_pkg::PIN_IO_CONTROL_ADDR);
    // owner status sits at the spare offset above; it only reports, writes are dropped
    assign hit_pme = upstream_port_i && (req.addr == sgc_pkg::PME_OWNER_ADDR);

    // ------------------------------------------------------------
    // power event ownership
    // ------------------------------------------------------------
    // only two pins can be taken over; all others always follow software
    for (genvar n = 0; n < NUM_PINS; n++) begin : g_owner
        if (n == sgc_pkg::PME_PIN_DSP1) begin : g_dsp1
            assign pme_own[n] = vendor_power_event_capability_en_i[0];
            assign pme_d[n] = pme_drive_i[0];
            assign pme_e[n] = pme_oe_i[0];
        end else if (n == sgc_pkg::PME_PIN_DSP2) begin : g_dsp2
            assign pme_own[n] = vendor_power_event_capability_en_i[1];
            assign pme_d[n] = pme_drive_i[1];
            assign pme_e[n] = pme_oe_i[1];
        end else begin : g_plain
            assign pme_own[n] = 1'b0;
            assign pme_d[n] = 1'b0;
            assign pme_e[n] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pin cells
    // ------------------------------------------------------------
    // one cell per pin keeps sample and drive in flops, so every pin output is registered
    for (genvar n = 0; n < NUM_PINS; n++) begin : g_pin
        sgc_pin_cell #(
            .LEVEL_RESET(sgc_pkg::INPUT_RESET[n]),
            .DRIVE_RESET(sgc_pkg::OUT_RESET[n]),
            .OE_RESET(sgc_pkg::DIR_RESET[n])
        ) u_cell (
            .sys_clk_i(sys_clk_i),
            .rst_b_i(rst_b_i),
            .clk_en_i(clk_en_i),
            .pin_in_i(pin_in_i[n]),
            .dir_i(state.dir[n]),
            .out_val_i(state.out_val[n]),
            .pme_own_i(pme_own[n]),
            .pme_drive_i(pme_d[n]),
            .pme_oe_i(pme_e[n]),
            .level_o(level[n]),
            .drive_o(pins.dout[n]),
            .oe_o(pins.oe[n])
        );
    end

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    logic wr_ctl;
    logic rd_ctl;
    logic rd_own;
    logic [NUM_PINS-1:0] dir_wr;
    logic [NUM_PINS-1:0] out_wr;
    logic [sgc_pkg::DATA_W-1:0] ctl_word;
    logic [sgc_pkg::DATA_W-1:0] own_word;

    assign wr_ctl = req.wr && hit_ctl;
    assign rd_ctl = req.rd && hit_ctl;
    assign rd_own = req.rd && hit_pme;

    // only direction and output value are taken; input and reserved bits fall away
    for (genvar n = 0; n < NUM_PINS; n++) begin : g_wr_field
        assign dir_wr[n] = req.wdata[sgc_pkg::BITS_PER_PIN*n + sgc_pkg::FLD_DIR];
        assign out_wr[n] = req.wdata[sgc_pkg::BITS_PER_PIN*n + sgc_pkg::FLD_OUT];
    end

    // control word as software sees it
    always_comb begin
        ctl_word = sgc_pkg::RDATA_RESET;
        for (int n = 0; n < NUM_PINS; n++) begin
            ctl_word[sgc_pkg::BITS_PER_PIN*n + sgc_pkg::FLD_INPUT] = level[n];
            ctl_word[sgc_pkg::BITS_PER_PIN*n + sgc_pkg::FLD_DIR] = state.dir[n];
            ctl_word[sgc_pkg::BITS_PER_PIN*n + sgc_pkg::FLD_OUT] = state.out_val[n];
            ctl_word[sgc_pkg::BITS_PER_PIN*n + sgc_pkg::FLD_RSVD] = 1'b0;
        end
    end

    // read-only view of which pins the power event logic owns
    always_comb begin
        own_word = sgc_pkg::RDATA_RESET;
        own_word[sgc_pkg::PME_PIN_DSP1] = vendor_power_event_capability_en_i[0];
        own_word[sgc_pkg::PME_PIN_DSP2] = vendor_power_event_capability_en_i[1];
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // read data stand for one enabled cycle and then fall back to zero
    always_comb begin
        next_state = state;
        next_state.rdata = sgc_pkg::RDATA_RESET;
        if (wr_ctl) begin
            next_state.dir = dir_wr;
            next_state.out_val = out_wr;
        end
        // any other offset, or a downstream port, reads back zero
        if (rd_ctl) begin
            next_state.rdata = ctl_word;
        end else if (rd_own) begin
            next_state.rdata = own_word;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset wins over the enable, so a frozen block can still be reset
    // a low enable freezes every flop, read data included
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state <= STATE_RESET;
        end else if (clk_en_i) begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_o = state.rdata;
    assign pin_out_o = pins.dout;
    assign pin_oe_o = pins.oe;
endmodule : sgc_gpio

// ---- testbench/sgc_checker.sv ----
// checker: port-level assertions for the pin control block
`timescale 1ns/1ps
module sgc_checker #(
    parameter int NUM_PINS = 8
) (
    // watched ports
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic upstream_port_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [1:0] vendor_power_event_capability_en_i,
    input wire logic [1:0] pme_drive_i,
    input wire logic [1:0] pme_oe_i,
    input wire logic [NUM_PINS-1:0] pin_in_i,
    input wire logic [NUM_PINS-1:0] pin_out_o,
    input wire logic [NUM_PINS-1:0] pin_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire rd_b8 = reg_rd_i && clk_en_i && upstream_port_i && reg_addr_i == 8'hB8;
    wire wr_b8 = reg_wr_i && clk_en_i && upstream_port_i && reg_addr_i == 8'hB8;
    function automatic logic [7:0] fld(logic [31:0] w, int k);
        for (int n = 0; n < 8; n++) fld[n] = w[4*n+k];
    endfunction : fld
    a_input_echo: assert property ($past(rd_b8) && $past(rst_b_i, 2)
        && $past(clk_en_i, 2) |-> fld(reg_rdata_o, 0) == $past(pin_in_i, 2))
        else $error("input bits wrong");
    a_dir_follow: assert property (wr_b8 ##1 (!reg_wr_i && clk_en_i) |=>
        (pin_oe_o & 8'hFC) == (fld($past(reg_wdata_i, 2), 1) & 8'hFC)) else $error("dir off");
    a_out_follow: assert property (wr_b8 ##1 (!reg_wr_i && clk_en_i) |=>
        (pin_out_o & pin_oe_o & 8'hFC) == (fld($past(reg_wdata_i, 2), 2)
        & fld($past(reg_wdata_i, 2), 1) & 8'hFC)) else $error("output value off");
    a_pme_pin0: assert property ((vendor_power_event_capability_en_i[0] && clk_en_i) [*2] |=>
        pin_oe_o[0] == $past(pme_oe_i[0]) && pin_out_o[0] == $past(pme_drive_i[0]))
        else $error("pin 0 owner wrong");
    a_pme_pin1: assert property ((vendor_power_event_capability_en_i[1] && clk_en_i) [*2] |=>
        pin_oe_o[1] == $past(pme_oe_i[1]) && pin_out_o[1] == $past(pme_drive_i[1]))
        else $error("pin 1 owner wrong");
    a_unmapped_zero: assert property ($past(reg_rd_i && clk_en_i &&
        (!upstream_port_i || reg_addr_i[7:3] != 5'h17)) |-> reg_rdata_o == 32'h0)
        else $error("unmapped read nonzero");
    a_rsvd_zero: assert property ($past(rd_b8) |-> fld(reg_rdata_o, 3) == 8'h0)
        else $error("reserved bits nonzero");
endmodule : sgc_checker
bind sgc_gpio sgc_checker #(.NUM_PINS(NUM_PINS)) u_chk (.*);

// ---- testbench/sgc_board.sv ----
// board model: resolves each pin from port drive, board drive and pull-up
`timescale 1ns/1ps
module sgc_board (
    // from the port
    input wire logic [7:0] pin_out_i,
    input wire logic [7:0] pin_oe_i,
    // board drivers
    input wire logic [7:0] ext_val_i,
    input wire logic [7:0] ext_en_i,
    // wire level
    output logic [7:0] pin_lvl_o
);
    // board drivers are weak, so the port wins; a floating pin is pulled up
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            pin_lvl_o[n] = pin_oe_i[n] ? pin_out_i[n] : (ext_en_i[n] ? ext_val_i[n] : 1'b1);
        end
    end
endmodule : sgc_board

// ---- testbench/tb_top.sv ----
// testbench: random and corner register traffic against the pin control block
`timescale 1ns/1ps
module tb_top;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic up = 1'b1;
    logic en = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata, q, d;
    logic [1:0] pen = 2'h0, pdrv = 2'h0, poe = 2'h0;
    logic [7:0] ext_val = 8'h00, ext_en = 8'h00, lvl, pout, pdir, dir_m = 8'h00, out_m = 8'h00;
    logic [15:0] p;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    sgc_gpio u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(en),
        .upstream_port_i(up), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .vendor_power_event_capability_en_i(pen),
        .pme_drive_i(pdrv), .pme_oe_i(poe), .pin_in_i(lvl), .pin_out_o(pout), .pin_oe_o(pdir));
    sgc_board u_brd (.pin_out_i(pout), .pin_oe_i(pdir), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .pin_lvl_o(lvl));
    initial forever #25 sys_clk_i = ~sys_clk_i;
    function automatic logic [15:0] exp_pins();
        logic [15:0] r;
        for (int n = 0; n < 8; n++) begin
            r[8+n] = (n < 2 && pen[n]) ? poe[n] : dir_m[n];
            r[n] = (n < 2 && pen[n]) ? pdrv[n] : out_m[n];
            if (!r[8+n]) r[n] = ext_en[n] ? ext_val[n] : 1'b1;
        end
        return r;
    endfunction : exp_pins
    function automatic logic [31:0] exp_word(logic [7:0] in);
        logic [31:0] r = 32'h00000000;
        for (int n = 0; n < 8; n++) r[4*n +: 3] = {out_m[n], dir_m[n], in[n]};
        return r;
    endfunction : exp_word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= v;
        wr <= w;
        rd <= !w;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdata;
    endtask : bus
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        void'($urandom(13070));
        repeat (4) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        bus(1'b0, 8'hB8, 32'h0);
        chk(q, 32'h11111111);
        for (int i = 0; i < 24; i++) begin
            d = (i == 0) ? 32'hFFFFFFFF : $urandom;
            @(posedge sys_clk_i);
            {pen, pdrv, poe} <= (i < 8) ? 6'h00 : 6'($urandom);
            ext_val <= 8'($urandom);
            ext_en <= 8'($urandom);
            bus(1'b1, 8'hB8, d);
            for (int n = 0; n < 8; n++) begin
                dir_m[n] = d[4*n+1];
                out_m[n] = d[4*n+2];
            end
            repeat (3) @(posedge sys_clk_i);
            bus(1'b0, 8'hB8, 32'h0);
            p = exp_pins();
            chk(q, exp_word(p[7:0]));
            chk({16'h0, pdir, lvl}, {16'h0, p});
            bus(1'b0, 8'hBC, 32'h0);
            chk(q, {30'h0, pen});
        end
        // frozen block: a write is dropped and the pins hold
        @(posedge sys_clk_i);
        en <= 1'b0;
        bus(1'b1, 8'hB8, ~d);
        chk({24'h0, pdir}, {24'h0, p[15:8]});
        @(posedge sys_clk_i);
        en <= 1'b1;
        bus(1'b0, 8'hB8, 32'h0);
        chk(q, exp_word(p[7:0]));
        bus(1'b0, 8'hB4, 32'h0);
        chk(q, 32'h0);
        @(posedge sys_clk_i);
        {pen, pdrv, poe} <= 6'h00;
        up <= 1'b0;
        rst_b_i <= 1'b0;
        @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        bus(1'b1, 8'hB8, 32'hFFFFFFFF);
        repeat (3) @(posedge sys_clk_i);
        bus(1'b0, 8'hB8, 32'h0);
        chk(q, 32'h0);
        chk({24'h0, pdir}, 32'h0);
        conclude();
    end
endmodule : tb_top
